/* File: verilog/pswc_pkg.sv */
package pswc_pkg;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS = 8'h00;   // control bits
  localparam logic [7:0] STAT_OFS = 8'h04;   // state, read only
  localparam logic [7:0] IRQ_OFS = 8'h08;    // sticky events, clear on read
  localparam logic [7:0] MASK_OFS = 8'h0C;   // interrupt mask

  // ----------------------------------------------------------------
  // control field positions
  // ----------------------------------------------------------------
  localparam int PSTOP_BIT = 0;     // pseudo_stop_select
  localparam int MON_EN_BIT = 1;       // clock_monitor_enable
  localparam int SELF_EN_BIT = 2;      // self_clock_mode_enable
  localparam int SELF_IRQ_EN_BIT = 3;  // self_clock_irq_enable
  localparam int MSEL_BIT = 4;      // multiplied_clock_select
  localparam int STOP_REQ_BIT = 5;  // write 1 with PSTOP_BIT set enters stop, reads 0

  // reset value of control: monitor and self clock enabled
  localparam logic [4:0] CTRL_RST = 5'h06;

  // ----------------------------------------------------------------
  // event bit positions (irq and mask)
  // ----------------------------------------------------------------
  localparam int EV_EXT = 0;    // external reset taken
  localparam int EV_WDOG = 1;   // watchdog reset taken
  localparam int EV_CMF = 2;    // clock monitor fail reset taken
  localparam int EV_SELF = 3;   // self_clock_irq_flag
  localparam int EV_WAKE = 4;   // interrupt wake-up
  localparam int EV_N = 5;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int RST_SEQ_NS = 1000;   // reset sequence length
  localparam int RST_SEQ_CYC = (RST_SEQ_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0] RST_SEQ_CNT = 8'(RST_SEQ_CYC);

  // ----------------------------------------------------------------
  // reset vector choice
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    PSWC_VEC_NORMAL = 2'h0,
    PSWC_VEC_WDOG = 2'h1,
    PSWC_VEC_CMF = 2'h2
  } pswc_vec_t;

  // wake-up causes sampled from the pins
  typedef struct packed {
    logic ext_reset;   // external reset request
    logic wdog_reset;  // watchdog_timer_unit reset
    logic clk_fail;    // clock monitor loss detection
    logic wake_irq;    // other enabled interrupt, e.g. periodic tick
  } pswc_cause_t;

  // outputs toward the core
  typedef struct packed {
    logic in_stop;          // device sits in pseudo stop
    logic reset_active;     // reset generator running
    logic vec_valid;        // vector choice stands
    pswc_vec_t vector;      // which reset vector to fetch
    logic self_clock_mode;  // running on self clock
    logic quality_start;    // clock quality checker start pulse
    logic mult_clk_sel;     // multiplied_clock_select
  } pswc_out_t;

endpackage

/* File: verilog/pswc_wakeup.sv */
module pswc_wakeup (
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // wake-up causes
  input wire pswc_pkg::pswc_cause_t cause,
  // core side
  output pswc_pkg::pswc_out_t core,
  output logic irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum {
    PSWC_RUN,
    PSWC_STOP,
    PSWC_RESET_SEQ
  } pswc_state_t;

  pswc_state_t state, next_state;
  logic [4:0] ctrl, next_ctrl;              // control bits
  logic [pswc_pkg::EV_N-1:0] ev, next_ev;   // sticky events
  logic [pswc_pkg::EV_N-1:0] mask, next_mask;
  logic [7:0] cnt, next_cnt;                // reset sequence counter
  pswc_pkg::pswc_out_t next_core;
  logic next_irq;
  // bus state
  logic aw_hold, next_aw_hold;   // write address captured
  logic w_hold, next_w_hold;     // write data captured
  logic [7:0] aw_q, next_aw_q;
  logic [31:0] w_q, next_w_q;
  logic [3:0] s_q, next_s_q;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // address decode, used by both read and write paths
  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == pswc_pkg::CTRL_OFS) || (a == pswc_pkg::STAT_OFS) ||
                 (a == pswc_pkg::IRQ_OFS) || (a == pswc_pkg::MASK_OFS);
  endfunction

  logic wr_go;       // write executes this cycle
  logic rd_go;       // read executes this cycle
  logic irq_rd;      // read of the event register
  logic [31:0] rd_val;
  logic clk_fail_on; // clock fail that counts

  // ----------------------------------------------------------------
  // axi4-lite slave, next values
  // ----------------------------------------------------------------
  always_comb
  begin
    next_aw_hold = aw_hold;
    next_w_hold = w_hold;
    next_aw_q = aw_q;
    next_w_q = w_q;
    next_s_q = s_q;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid;
    next_rresp = s_axi_rresp;
    next_rdata = s_axi_rdata;
    wr_go = 1'b0;
    rd_go = 1'b0;
    // capture address and data in either order
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_hold = 1'b1;
      next_aw_q = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_hold = 1'b1;
      next_w_q = s_axi_wdata;
      next_s_q = s_axi_wstrb;
    end
    // both held and no response pending: perform write
    if (aw_hold && w_hold && !s_axi_bvalid)
    begin
      wr_go = 1'b1;
      next_aw_hold = 1'b0;
      next_w_hold = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = known_addr(aw_q) ? 2'h0 : 2'h2;
    end
    else if (s_axi_bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    // read answer one cycle after address
    if (s_axi_arvalid && s_axi_arready)
    begin
      rd_go = 1'b1;
      next_rvalid = 1'b1;
      next_rdata = rd_val;
      next_rresp = known_addr(s_axi_araddr) ? 2'h0 : 2'h2;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready = !next_w_hold && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // read mux
  always_comb
  begin
    rd_val = 32'h0000_0000;
    unique case (s_axi_araddr)
      pswc_pkg::CTRL_OFS: rd_val = {27'h0, ctrl};
      pswc_pkg::STAT_OFS: rd_val = {24'h0, core.self_clock_mode, core.vector,
                                    core.vec_valid, core.reset_active,
                                    (state == PSWC_STOP), 2'(state)};
      pswc_pkg::IRQ_OFS: rd_val = {27'h0, ev};
      pswc_pkg::MASK_OFS: rd_val = {27'h0, mask};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  assign irq_rd = rd_go && (s_axi_araddr == pswc_pkg::IRQ_OFS);
  // clock loss counts only while monitor is on
  assign clk_fail_on = cause.clk_fail && ctrl[pswc_pkg::MON_EN_BIT];

  // ----------------------------------------------------------------
  // wake-up sequencer, next values
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [pswc_pkg::EV_N-1:0] set_ev;
    set_ev = '0;
    next_state = state;
    next_ctrl = ctrl;
    next_cnt = cnt;
    next_core = core;
    next_core.quality_start = 1'b0;
    next_mask = mask;
    // software writes to control and mask
    if (wr_go && s_q[0])
    begin
      if (aw_q == pswc_pkg::CTRL_OFS)
      begin
        next_ctrl = w_q[4:0];
      end
      if (aw_q == pswc_pkg::MASK_OFS)
      begin
        next_mask = w_q[pswc_pkg::EV_N-1:0];
      end
    end
    unique case (state)
      PSWC_RUN:
      begin
        next_core.in_stop = 1'b0;
        // external or watchdog reset in run also restarts
        if (cause.ext_reset || cause.wdog_reset)
        begin
          next_state = PSWC_RESET_SEQ;
          next_ctrl = pswc_pkg::CTRL_RST;
          next_cnt = pswc_pkg::RST_SEQ_CNT;
          next_core.vector = cause.ext_reset ? pswc_pkg::PSWC_VEC_NORMAL
                                             : pswc_pkg::PSWC_VEC_WDOG;
          next_core.reset_active = 1'b1;
          next_core.vec_valid = 1'b0;
          set_ev[cause.ext_reset ? pswc_pkg::EV_EXT : pswc_pkg::EV_WDOG] = 1'b1;
        end
        else if (wr_go && s_q[0] && aw_q == pswc_pkg::CTRL_OFS &&
                 w_q[pswc_pkg::STOP_REQ_BIT] && w_q[pswc_pkg::PSTOP_BIT])
        begin
          next_state = PSWC_STOP;
          next_core.in_stop = 1'b1;
        end
      end
      PSWC_STOP:
      begin
        // causes taken in priority: resets, clock fail, interrupt
        if (cause.ext_reset || cause.wdog_reset)
        begin
          next_state = PSWC_RESET_SEQ;
          next_ctrl = pswc_pkg::CTRL_RST;
          next_core.in_stop = 1'b0;        // stop is left at reset start
          next_cnt = pswc_pkg::RST_SEQ_CNT;
          next_core.reset_active = 1'b1;
          next_core.vec_valid = 1'b0;
          next_core.self_clock_mode = 1'b0;
          next_core.mult_clk_sel = 1'b0;
          next_core.vector = cause.ext_reset ? pswc_pkg::PSWC_VEC_NORMAL
                                             : pswc_pkg::PSWC_VEC_WDOG;
          set_ev[cause.ext_reset ? pswc_pkg::EV_EXT : pswc_pkg::EV_WDOG] = 1'b1;
        end
        else if (clk_fail_on && !ctrl[pswc_pkg::SELF_EN_BIT])
        begin
          // clock monitor fail reset, own vector
          next_state = PSWC_RESET_SEQ;
          next_core.in_stop = 1'b0;
          next_ctrl = pswc_pkg::CTRL_RST;
          next_cnt = pswc_pkg::RST_SEQ_CNT;
          next_core.reset_active = 1'b1;
          next_core.vec_valid = 1'b0;
          next_core.mult_clk_sel = 1'b0;
          next_core.vector = pswc_pkg::PSWC_VEC_CMF;
          set_ev[pswc_pkg::EV_CMF] = 1'b1;
        end
        else if (clk_fail_on)
        begin
          set_ev[pswc_pkg::EV_SELF] = 1'b1;
          if (ctrl[pswc_pkg::SELF_IRQ_EN_BIT])
          begin
            // interrupt, then self clock and checker, resume
            next_state = PSWC_RUN;
            next_core.in_stop = 1'b0;
            next_core.self_clock_mode = 1'b1;
            next_core.quality_start = 1'b1;
            next_ctrl[pswc_pkg::MSEL_BIT] = 1'b0;
          end
        end
        else if (cause.wake_irq)
        begin
          // plain wake-up, no reset sequence
          next_state = PSWC_RUN;
          next_core.in_stop = 1'b0;
          next_ctrl[pswc_pkg::MSEL_BIT] = 1'b0;
          set_ev[pswc_pkg::EV_WAKE] = 1'b1;
        end
      end
      PSWC_RESET_SEQ:
      begin
        // count out the reset sequence, then present vector
        next_ctrl = pswc_pkg::CTRL_RST;
        if (cnt <= 8'h01)
        begin
          next_state = PSWC_RUN;
          next_core.reset_active = 1'b0;
          next_core.vec_valid = 1'b1;
          next_core.in_stop = 1'b0;
        end
        else
        begin
          next_cnt = cnt - 8'h01;
        end
      end
    endcase
    next_core.mult_clk_sel = next_ctrl[pswc_pkg::MSEL_BIT];
    // set wins over clear on read
    next_ev = (irq_rd ? '0 : ev) | set_ev;
    next_irq = |(next_ev & next_mask);
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= PSWC_RUN;
      ctrl <= pswc_pkg::CTRL_RST;
      ev <= '0;
      mask <= '0;
      cnt <= 8'h00;
      core <= '0;
      irq <= 1'b0;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_q <= 8'h00;
      w_q <= 32'h0000_0000;
      s_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      ctrl <= next_ctrl;
      ev <= next_ev;
      mask <= next_mask;
      cnt <= next_cnt;
      core <= next_core;
      irq <= next_irq;
      aw_hold <= next_aw_hold;
      w_hold <= next_w_hold;
      aw_q <= next_aw_q;
      w_q <= next_w_q;
      s_q <= next_s_q;
      s_axi_awready <= next_awready;
      s_axi_wready <= next_wready;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_arready <= next_arready;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
    end
  end

endmodule

/* File: tb/pswc_monitor.sv */
module pswc_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire pswc_pkg::pswc_cause_t cause,
  input wire pswc_pkg::pswc_out_t core
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // timing and sequences
  // ----------------------------------------------------------------
  localparam int SEQ = pswc_pkg::RST_SEQ_CYC;  // reset sequence cycles
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // generator runs its full length, then the vector stands
  sequence seq_reset_done;
    core.reset_active ##SEQ (!core.reset_active && core.vec_valid);
  endsequence
  // checker start is a lone pulse while on self clock
  sequence seq_self_pulse;
    (core.self_clock_mode && !core.in_stop) ##1 !core.quality_start;
  endsequence
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  reset_seq_a: assert property (
    $rose(core.reset_active) |-> seq_reset_done)
    else $error("reset sequence length wrong");
  hard_reset_a: assert property (
    core.in_stop && (cause.ext_reset || cause.wdog_reset) |=> core.reset_active)
    else $error("reset cause did not start generator");
  wdog_vec_a: assert property (
    core.in_stop && cause.wdog_reset && !cause.ext_reset
    |=> core.vector == pswc_pkg::PSWC_VEC_WDOG)
    else $error("watchdog vector not chosen");
  wake_run_a: assert property (
    core.in_stop && cause.wake_irq && !cause.ext_reset && !cause.wdog_reset
    && !cause.clk_fail |=> !core.in_stop && !core.reset_active)
    else $error("interrupt wake did not resume");
  stop_exit_a: assert property (
    $fell(core.in_stop) |-> !core.mult_clk_sel)
    else $error("multiplied select kept after stop");
  self_pulse_a: assert property (
    core.quality_start |-> seq_self_pulse)
    else $error("checker start pulse wrong");
  fail_wake_a: assert property (
    core.in_stop && cause.clk_fail && !cause.ext_reset && !cause.wdog_reset
    && !cause.wake_irq ##1 (!core.in_stop && !core.reset_active)
    |-> core.quality_start && core.self_clock_mode)
    else $error("clock fail exit without self clock");
  read_ans_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_ans_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
endmodule

bind pswc_wakeup pswc_monitor mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .cause, .core);

/* File: tb/pswc_cause_src.sv */
module pswc_cause_src (
  input wire logic aclk,
  input wire logic go,
  input wire pswc_pkg::pswc_cause_t req,
  input wire logic [3:0] len,
  output pswc_pkg::pswc_cause_t cause
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] left = 4'h0;  // cycles the cause still stands
  initial cause = '0;
  // hold a cause for len cycles, then back to idle
  always @(posedge aclk)
  begin
    if (go)
    begin
      cause <= req;
      left <= len;
    end
    else if (left > 4'h1)
      left <= left - 4'h1;
    else
    begin
      cause <= '0;
      left <= 4'h0;
    end
  end
endmodule

/* File: tb/pswc_wakeup_tb.sv */
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("Error at %0t: got %0h exp %0h", $time, (a), (e)); end end
module pswc_wakeup_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b1;  // always ready for answers
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b1;
  pswc_pkg::pswc_cause_t cause;
  pswc_pkg::pswc_out_t core;
  logic irq;
  pswc_pkg::pswc_cause_t req = '0;  // cause for the source model
  logic go = 1'b0;
  logic [3:0] len = 4'h1;
  logic [31:0] rd_v;  // last read data
  logic [1:0] resp;  // last response code
  int bad_count = 0;
  int total_checks = 0;
  int n;
  always #20 aclk = ~aclk;
  pswc_wakeup DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cause, .core, .irq);
  pswc_cause_src SRC (.aclk, .go, .req, .len, .cause);
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge aclk);
    #1;
  endtask
  // one write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      k++;
    end
    while (!s_axi_bvalid && k < 100);
    resp = s_axi_bresp;
    if (k >= 100) bad_count++;
    #1;
  endtask
  // one read
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      k++;
    end
    while (!s_axi_rvalid && k < 100);
    rd_v = s_axi_rdata;
    resp = s_axi_rresp;
    if (k >= 100) bad_count++;
    #1;
  endtask
  // raise one cause through the source model
  task automatic fire(input logic [3:0] c, input logic [3:0] l);
    @(posedge aclk);
    req <= pswc_pkg::pswc_cause_t'(c);
    len <= l;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    #1;
  endtask
  // set control, then request stop
  task automatic enter(input logic [31:0] c);
    wr(pswc_pkg::CTRL_OFS, c);
    wr(pswc_pkg::CTRL_OFS, c | 32'h20);
    cyc(1);
    `CHK(core.in_stop, 1'b1)
  endtask
  // time the reset generator, then check vector and defaults
  task automatic seq_check(input pswc_pkg::pswc_vec_t v);
    n = 0;
    while (!core.reset_active && n < 20)
    begin
      cyc(1);
      n++;
    end
    n = 0;
    while (core.reset_active && n < 60)
    begin
      cyc(1);
      n++;
    end
    `CHK(n, pswc_pkg::RST_SEQ_CYC)
    `CHK(core.vector, v)
    `CHK(core.vec_valid, 1'b1)
    `CHK(core.in_stop, 1'b0)
    rd(pswc_pkg::CTRL_OFS);
    `CHK(rd_v, 32'(pswc_pkg::CTRL_RST))
  endtask
  task automatic conclude;
    if (bad_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    rd(pswc_pkg::CTRL_OFS);
    `CHK(rd_v, 32'(pswc_pkg::CTRL_RST))
    rd(pswc_pkg::MASK_OFS);
    `CHK(rd_v, 32'h0)
    rd(8'h10);
    `CHK(resp, 2'h2)
    wr(8'h10, 32'hFF);
    `CHK(resp, 2'h2)
    // interrupt wake, masked first, then unmasked and cleared
    enter(32'h17);
    fire(4'h1, 4'h1);
    cyc(2);
    `CHK(core.in_stop, 1'b0)
    `CHK(core.reset_active, 1'b0)
    `CHK(core.mult_clk_sel, 1'b0)
    `CHK(irq, 1'b0)
    wr(pswc_pkg::MASK_OFS, 32'h1F);
    cyc(1);
    `CHK(irq, 1'b1)
    rd(pswc_pkg::IRQ_OFS);
    `CHK(rd_v, 32'h10)
    cyc(2);
    `CHK(irq, 1'b0)
    rd(pswc_pkg::CTRL_OFS);
    `CHK(rd_v, 32'h07)
    wr(pswc_pkg::CTRL_OFS, 32'h17);
    cyc(2);
    `CHK(core.mult_clk_sel, 1'b1)
    // monitor off: a long clock loss is ignored
    enter(32'h05);
    fire(4'h2, 4'h3);
    cyc(4);
    `CHK(core.in_stop, 1'b1)
    fire(4'h1, 4'h1);
    cyc(2);
    rd(pswc_pkg::IRQ_OFS);
    `CHK(rd_v, 32'h10)
    // self clock irq off: flag only, stays stopped
    enter(32'h07);
    fire(4'h2, 4'h1);
    cyc(3);
    `CHK(core.in_stop, 1'b1)
    rd(pswc_pkg::IRQ_OFS);
    `CHK(rd_v[3], 1'b1)
    fire(4'h1, 4'h1);
    cyc(2);
    rd(pswc_pkg::IRQ_OFS);
    // self clock path
    enter(32'h1F);
    fire(4'h2, 4'h1);
    cyc(2);
    `CHK(core.in_stop, 1'b0)
    `CHK(core.self_clock_mode, 1'b1)
    `CHK(core.mult_clk_sel, 1'b0)
    `CHK(irq, 1'b1)
    rd(pswc_pkg::IRQ_OFS);
    `CHK(rd_v, 32'h08)
    // external then watchdog reset from stop
    for (int i = 0; i < 2; i++)
    begin
      enter(32'h17);
      fire(i ? 4'h4 : 4'h8, 4'h1);
      seq_check(pswc_pkg::pswc_vec_t'(i));
      `CHK(core.self_clock_mode, 1'b0)
      rd(pswc_pkg::IRQ_OFS);
      `CHK(rd_v, 32'h1 << i)
    end
    // clock loss without self clock: reset, own vector
    enter(32'h03);
    fire(4'h2, 4'h1);
    seq_check(pswc_pkg::PSWC_VEC_CMF);
    rd(pswc_pkg::IRQ_OFS);
    `CHK(rd_v, 32'h04)
    conclude;
  end
  // watchdog against a hang
  initial
  begin
    #(40 * 5000);
    bad_count++;
    conclude;
  end
endmodule
